// file: hw/scd_spi_command_decoder.sv
// Serial command decoder for a two-output high-side switch: takes 16-bit
// command words over the serial link and keeps the configuration and
// control registers, the readback word and the output on/off state.
// Assumes select stays high at least four system clocks between frames.
//
// Operation
// - Each command is sixteen bits, most significant bit first.
// - Bits 14..10 pick the target register.
// - Bit 13 picks output zero or one for per-output registers.
// - Nine low bits are the payload for the addressed register.
// - Transfers not a multiple of sixteen bits change nothing.
// - Several words may follow in one select period, multiples of sixteen.
// - Address decode: status, per-output, global and calibration codes.
// - Status select payload chooses the next readback word.
// - Status select changes only the readback selector and no operation.
// - On bit drives output on; direct input high also drives it unless PWM or direct-disable is on.
// - Seven low PWM bits set duty cycle, used while PWM is enabled.
// - Direct-disable bit removes direct input control of the output.
// - Two slew bits: medium, low, high, unused.
// - Three delay bits set switching delay while PWM is enabled.
// - Reset pin, supply failure or reset zero every register.
// - Registers latch on select rising, only for valid lengths.
`timescale 1ns/10ps
`include "scd_params.svh"
module scd_spi_command_decoder (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_reset_n_pin,
    input wire logic i_supply_fail,
    input wire logic [1:0] i_direct_in,
    input wire logic [15:0] i_status_word,
    output logic o_so,
    output logic o_so_oe,
    output logic [1:0] o_output_drive,
    output logic [1:0] o_out_on,
    output logic [1:0][6:0] o_duty,
    output logic [1:0] o_direct_dis,
    output logic [1:0][1:0] o_slew,
    output logic [1:0][2:0] o_delay,
    output logic [1:0][8:0] o_fault_cfg,
    output logic [1:0][8:0] o_oc_cfg,
    output logic [8:0] o_global_cfg,
    output logic [8:0] o_clock_cal,
    output logic o_pwm_enable,
    output logic [4:0] o_readout_select,
    output logic o_watchdog_bit,
    output logic o_watchdog_strobe
);

    scd_link_if u_link_if();

    logic [4:0] sync1;
    logic [4:0] sync2;
    logic cs_prev;
    logic cs_rise;
    logic clr;
    logic last_tog;
    logic latch_valid;
    scd_pkg::scd_word_t word_q;
    scd_pkg::scd_kind_e word_kind;
    logic word_sel;
    scd_pkg::scd_data_t word_data;
    logic [1:0][8:0] pwm_reg;
    logic [1:0][8:0] sw_reg;
    logic [1:0][8:0] fault_reg;
    logic [1:0][8:0] oc_reg;
    scd_pkg::scd_data_t global_reg;
    scd_pkg::scd_data_t cal_reg;
    logic [4:0] sel_reg;
    scd_pkg::scd_word_t readback;
    scd_pkg::scd_word_t next_readback;
    logic [1:0] direct_s;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write path and the readback path
    function automatic scd_pkg::scd_kind_e kind_of(input logic [4:0] a);
        logic [2:0] low;
        low = a[2:0];
        if (low == `SCD_A_STATUS) begin
            kind_of = scd_pkg::SCD_K_STATUS;
        end else if (a == `SCD_A_GLOBAL) begin
            kind_of = scd_pkg::SCD_K_GLOBAL;
        end else if (a == `SCD_A_CAL) begin
            kind_of = scd_pkg::SCD_K_CAL;
        end else if (a[`SCD_A_PEROUT_BIT] && low == `SCD_A_PWM) begin
            kind_of = scd_pkg::SCD_K_PWM;
        end else if (a[`SCD_A_PEROUT_BIT] && low == `SCD_A_SWITCH) begin
            kind_of = scd_pkg::SCD_K_SWITCH;
        end else if (a[`SCD_A_PEROUT_BIT] && low == `SCD_A_FAULT) begin
            kind_of = scd_pkg::SCD_K_FAULT;
        end else if (a[`SCD_A_PEROUT_BIT] && low == `SCD_A_OVERCUR) begin
            kind_of = scd_pkg::SCD_K_OVERCUR;
        end else begin
            kind_of = scd_pkg::SCD_K_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial clock front end
    scd_spi_link u_link (
        .i_sclk(i_sclk),
        .i_srst(i_srst),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .lnk(u_link_if.link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for select, reset pin, supply fail, inputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1 <= `SCD_SYNC_RST;
            sync2 <= `SCD_SYNC_RST;
            cs_prev <= 1'b1;
        end else begin
            sync1 <= {i_cs_n, i_reset_n_pin, i_supply_fail, i_direct_in};
            sync2 <= sync1;
            cs_prev <= sync2[4];
        end
    end

    assign cs_rise = sync2[4] & ~cs_prev;
    assign direct_s = sync2[1:0];
    // Any of the three reset sources zeroes the registers
    assign clr = i_srst | ~sync2[3] | sync2[2];

    ////////////////////////////////////////////////////////////////////////
    // Frame end: the link words are quiet once select is high, so they are
    // sampled after the synchronised rising edge. A new toggle proves the
    // frame had clocks; a zero count proves whole words
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            last_tog <= 1'b0;
            latch_valid <= 1'b0;
            word_q <= `SCD_WORD_RST;
        end else if (cs_rise) begin
            last_tog <= u_link_if.frame_tog;
            latch_valid <= (u_link_if.frame_tog != last_tog) &&
                           (u_link_if.bit_cnt == `SCD_CNT_ZERO);
            word_q <= u_link_if.word;
        end else begin
            latch_valid <= 1'b0;
        end
    end

    // Field split of the held word; bit 9 is not looked at
    assign word_kind = kind_of(word_q[`SCD_ADDR_HI:`SCD_ADDR_LO]);
    assign word_sel = word_q[`SCD_SEL_BIT];
    assign word_data = word_q[`SCD_DATA_HI:0];

    ////////////////////////////////////////////////////////////////////////
    // Register writes; a status select touches only the selector
    always_ff @(posedge i_clk) begin
        if (clr) begin
            pwm_reg <= {2{`SCD_REG_RST}};
            sw_reg <= {2{`SCD_REG_RST}};
            fault_reg <= {2{`SCD_REG_RST}};
            oc_reg <= {2{`SCD_REG_RST}};
            global_reg <= `SCD_REG_RST;
            cal_reg <= `SCD_REG_RST;
            sel_reg <= `SCD_SEL_RST;
        end else if (latch_valid) begin
            case (word_kind)
                scd_pkg::SCD_K_STATUS: begin
                    sel_reg <= word_data[`SCD_SOA_HI:0];
                end
                scd_pkg::SCD_K_PWM: begin
                    // Bit 8 is stored as sent; the host keeps it low
                    pwm_reg[word_sel] <= word_data;
                end
                scd_pkg::SCD_K_SWITCH: begin
                    sw_reg[word_sel] <= word_data;
                end
                scd_pkg::SCD_K_FAULT: begin
                    fault_reg[word_sel] <= word_data;
                end
                scd_pkg::SCD_K_OVERCUR: begin
                    oc_reg[word_sel] <= word_data;
                end
                scd_pkg::SCD_K_GLOBAL: begin
                    global_reg <= word_data;
                end
                scd_pkg::SCD_K_CAL: begin
                    cal_reg <= word_data;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback word for the first sixteen bits of the next frame: status
    // as given, a register as its own command word
    always_comb begin
        next_readback = `SCD_WORD_RST;
        case (kind_of(sel_reg))
            scd_pkg::SCD_K_STATUS: next_readback = i_status_word;
            scd_pkg::SCD_K_PWM:
                next_readback = {1'b0, sel_reg, 1'b0, pwm_reg[sel_reg[3]]};
            scd_pkg::SCD_K_SWITCH:
                next_readback = {1'b0, sel_reg, 1'b0, sw_reg[sel_reg[3]]};
            scd_pkg::SCD_K_FAULT:
                next_readback = {1'b0, sel_reg, 1'b0, fault_reg[sel_reg[3]]};
            scd_pkg::SCD_K_OVERCUR:
                next_readback = {1'b0, sel_reg, 1'b0, oc_reg[sel_reg[3]]};
            scd_pkg::SCD_K_GLOBAL:
                next_readback = {1'b0, sel_reg, 1'b0, global_reg};
            scd_pkg::SCD_K_CAL:
                next_readback = {1'b0, sel_reg, 1'b0, cal_reg};
            default: next_readback = `SCD_WORD_RST;
        endcase
    end

    // Registered so the link side sees a steady word between frames
    always_ff @(posedge i_clk) begin
        if (clr) begin
            readback <= `SCD_WORD_RST;
        end else begin
            readback <= next_readback;
        end
    end

    assign u_link_if.readback = readback;

    ////////////////////////////////////////////////////////////////////////
    // Output state: the on bit always switches on; with PWM enabled the
    // direct input is ignored, otherwise it can hold the output on unless
    // direct control is disabled. Duty and delay are only used by the PWM
    // engine outside this block
    always_ff @(posedge i_clk) begin
        if (clr) begin
            o_output_drive <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                o_output_drive[i] <= pwm_reg[i][`SCD_ON_BIT] |
                    (~global_reg[`SCD_PWMEN_BIT] & direct_s[i] &
                     ~sw_reg[i][`SCD_DIRDIS_BIT]);
            end
        end
    end

    // Field views of the stored registers
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            o_out_on[i] = pwm_reg[i][`SCD_ON_BIT];
            o_duty[i] = pwm_reg[i][`SCD_DUTY_HI:0];
            o_direct_dis[i] = sw_reg[i][`SCD_DIRDIS_BIT];
            o_slew[i] = sw_reg[i][`SCD_SLEW_HI:`SCD_SLEW_LO];
            o_delay[i] = sw_reg[i][`SCD_DELAY_HI:0];
        end
    end

    assign o_fault_cfg = fault_reg;
    assign o_oc_cfg = oc_reg;
    assign o_global_cfg = global_reg;
    assign o_clock_cal = cal_reg;
    assign o_pwm_enable = global_reg[`SCD_PWMEN_BIT];
    assign o_readout_select = sel_reg;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog bit of every latched word, with a strobe for the monitor
    always_ff @(posedge i_clk) begin
        if (clr) begin
            o_watchdog_bit <= 1'b0;
            o_watchdog_strobe <= 1'b0;
        end else begin
            o_watchdog_strobe <= latch_valid;
            if (latch_valid) begin
                o_watchdog_bit <= word_q[`SCD_WD_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_latch_on_rise: assert property (@(posedge i_clk)
        disable iff (i_srst) cs_rise && u_link_if.frame_tog != last_tog &&
        u_link_if.bit_cnt == 4'h0 |=> latch_valid)
        else $error("valid frame not latched");

    a_bad_len_drop: assert property (@(posedge i_clk)
        disable iff (i_srst) cs_rise && u_link_if.bit_cnt != 4'h0 ##1 !clr
        |=> $stable(global_reg) && $stable(pwm_reg) && $stable(sw_reg))
        else $error("partial frame changed a register");

    a_status_no_side: assert property (@(posedge i_clk)
        disable iff (i_srst)
        latch_valid && word_kind == scd_pkg::SCD_K_STATUS && !clr
        |=> $stable(global_reg) && $stable(pwm_reg) && $stable(oc_reg) &&
            sel_reg == $past(word_q[4:0]))
        else $error("status select disturbed a register");

    a_pwm_select: assert property (@(posedge i_clk)
        disable iff (i_srst)
        latch_valid && word_kind == scd_pkg::SCD_K_PWM && !clr
        |=> pwm_reg[$past(word_q[13])] == $past(word_q[8:0]))
        else $error("pwm word went to the wrong output");

    a_global_decode: assert property (@(posedge i_clk)
        disable iff (i_srst) latch_valid && word_q[14:10] == 5'h05 && !clr
        |=> global_reg == $past(word_q[8:0]) && $stable(cal_reg))
        else $error("global address decoded wrongly");

    a_drive_on: assert property (@(posedge i_clk)
        disable iff (i_srst) pwm_reg[0][7] && !clr |=> o_output_drive[0])
        else $error("on bit did not drive the output");

    a_direct_off: assert property (@(posedge i_clk)
        disable iff (i_srst) sw_reg[0][5] && !pwm_reg[0][7] && !clr
        |=> !o_output_drive[0])
        else $error("disabled direct input still drives");

    a_reset_zero: assert property (@(posedge i_clk)
        disable iff (i_srst) clr |=> global_reg == 9'h000 &&
        pwm_reg == 18'h00000 && cal_reg == 9'h000 && sel_reg == 5'h00)
        else $error("reset source left a register set");

    a_wd_capture: assert property (@(posedge i_clk)
        disable iff (i_srst) latch_valid && !clr
        |=> o_watchdog_strobe && o_watchdog_bit == $past(word_q[15]))
        else $error("watchdog bit not passed on");

    a_readback_sel: assert property (@(posedge i_clk)
        disable iff (i_srst) kind_of(sel_reg) == scd_pkg::SCD_K_GLOBAL && !clr
        |=> readback == {1'b0, $past(sel_reg), 1'b0, $past(global_reg)})
        else $error("readback does not follow the selector");

endmodule

// file: hw/scd_params.svh
// Constants of the serial command decoder: word layout, address codes,
// field positions and reset values.
// Assumes it is included by its bare name wherever a constant is used.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// Word layout
`define SCD_WORD_W 16
`define SCD_DATA_W 9
`define SCD_CNT_W 4
`define SCD_WD_BIT 15
`define SCD_SEL_BIT 13
`define SCD_ADDR_HI 14
`define SCD_ADDR_LO 10
`define SCD_DATA_HI 8

// Address codes, low three bits for the per-output registers
`define SCD_A_STATUS 3'h0
`define SCD_A_PWM 3'h1
`define SCD_A_SWITCH 3'h2
`define SCD_A_FAULT 3'h3
`define SCD_A_OVERCUR 3'h4
`define SCD_A_GLOBAL 5'h05
`define SCD_A_CAL 5'h07
`define SCD_A_PEROUT_BIT 4

// Field positions inside the nine payload bits
`define SCD_ON_BIT 7
`define SCD_DUTY_HI 6
`define SCD_DIRDIS_BIT 5
`define SCD_SLEW_HI 4
`define SCD_SLEW_LO 3
`define SCD_DELAY_HI 2
`define SCD_PWMEN_BIT 7
`define SCD_SOA_HI 4

// Reset values
`define SCD_REG_RST 9'h000
`define SCD_WORD_RST 16'h0000
`define SCD_CNT_ZERO 4'h0
`define SCD_CNT_ONE 4'h1
`define SCD_SEL_RST 5'h00
`define SCD_SYNC_RST 5'h18

`endif

// file: hw/scd_pkg.sv
// Types shared by the serial command decoder modules.
// Assumes the constants header is compiled alongside.
package scd_pkg;

    typedef logic [15:0] scd_word_t;
    typedef logic [8:0] scd_data_t;

    // Register a decoded command word is aimed at
    typedef enum logic [2:0] {
        SCD_K_NONE    = 3'h0,
        SCD_K_STATUS  = 3'h1,
        SCD_K_PWM     = 3'h3,
        SCD_K_SWITCH  = 3'h2,
        SCD_K_FAULT   = 3'h6,
        SCD_K_OVERCUR = 3'h7,
        SCD_K_GLOBAL  = 3'h5,
        SCD_K_CAL     = 3'h4
    } scd_kind_e;

endpackage

// file: hw/scd_link_if.sv
// Carrier between the serial-clock front end and the register core.
// Assumes the word, count and toggle are only read while select is high,
// when the serial clock stands still.
`timescale 1ns/10ps
interface scd_link_if;
    scd_pkg::scd_word_t word;
    logic [3:0] bit_cnt;
    logic frame_tog;
    scd_pkg::scd_word_t readback;

    modport link (
        output word,
        output bit_cnt,
        output frame_tog,
        input readback
    );
    modport core (
        input word,
        input bit_cnt,
        input frame_tog,
        output readback
    );
endinterface

// file: hw/scd_spi_link.sv
// Serial-clock front end: one shift register that sends the readback word
// and takes in the command bits, a bit counter and a frame toggle.
// Assumes the host shifts on rising serial clock edges while select is low.
`timescale 1ns/10ps
`include "scd_params.svh"
module scd_spi_link (
    input wire logic i_sclk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    scd_link_if.link lnk
);

    logic fresh;
    scd_pkg::scd_word_t shreg;
    logic [3:0] cnt;
    logic tog;

    ////////////////////////////////////////////////////////////////////////
    // Frame start flag, set while select is high
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Shift in MSB first; first edge of a frame loads the readback word
    // so the first sixteen bits out are the readback
    always_ff @(posedge i_sclk or posedge i_srst) begin
        if (i_srst) begin
            shreg <= `SCD_WORD_RST;
            cnt <= `SCD_CNT_ZERO;
            tog <= 1'b0;
        end else if (fresh) begin
            shreg <= {lnk.readback[`SCD_WORD_W-2:0], i_si};
            cnt <= `SCD_CNT_ONE;
            tog <= ~tog;
        end else begin
            shreg <= {shreg[`SCD_WORD_W-2:0], i_si};
            cnt <= cnt + `SCD_CNT_ONE; // Wraps every word
        end
    end

    // Later bits out are the bits taken in, for daisy chains
    assign o_so = fresh ? lnk.readback[`SCD_WORD_W-1] :
                          shreg[`SCD_WORD_W-1];
    assign o_so_oe = ~i_cs_n;

    assign lnk.word = shreg;
    assign lnk.bit_cnt = cnt;
    assign lnk.frame_tog = tog;

    ////////////////////////////////////////////////////////////////////////
    a_shift_msb: assert property (@(posedge i_sclk)
        disable iff (i_srst) !fresh
        |=> shreg == {$past(shreg[14:0]), $past(i_si)})
        else $error("serial word not shifted msb first");

    a_count_step: assert property (@(posedge i_sclk)
        disable iff (i_srst) !fresh |=> cnt == 4'($past(cnt) + 4'h1))
        else $error("bit counter did not advance");

endmodule

// file: sim/scd_host_model.sv
// Host model: serial master that frames bits with select and clocks them.
// Assumes one caller at a time; serial clock idles low between frames.
`timescale 1ns/10ps
module scd_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    // Idle lines at time zero
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Send n bits MSB first at a 6 ns serial period, sampling SO ahead of
    // each rising edge since the device shifts SO on that edge
    task automatic xfer(input logic [47:0] bits, input int n,
                        output logic [47:0] seen);
        seen = '0;
        o_cs_n = 1'b0;
        #5;
        for (int i = n - 1; i >= 0; i--) begin
            o_si = bits[i];
            #3;
            seen = {seen[46:0], i_so};
            o_sclk = 1'b1;
            #3;
            o_sclk = 1'b0;
        end
        #5;
        o_cs_n = 1'b1;
        o_si = ~o_si; // No pull on the data line: never leave the last bit
    endtask
endmodule

// file: sim/spi_command_register_decoder_tb_top.sv
// Testbench for the serial command decoder, with the host model in front.
// Assumes the design latches a frame within eight clocks of select rising.
`timescale 1ns/10ps
module spi_command_register_decoder_tb_top;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_reset_n_pin = 1'b1;
    logic i_supply_fail = 1'b0;
    logic [1:0] i_direct_in = 2'b00;
    logic [15:0] i_status_word = 16'hA5C3;
    logic sclk, cs_n, si, o_so, o_so_oe, o_pwm_enable;
    logic o_watchdog_bit, o_watchdog_strobe;
    logic [1:0] o_output_drive, o_out_on, o_direct_dis;
    logic [1:0][6:0] o_duty;
    logic [1:0][1:0] o_slew;
    logic [1:0][2:0] o_delay;
    logic [1:0][8:0] o_fault_cfg, o_oc_cfg;
    logic [8:0] o_global_cfg, o_clock_cal;
    logic [4:0] o_readout_select;
    logic [15:0] rb, word;
    logic wd = 1'b0;
    int failures = 0;
    int checks = 0;
    int strobes = 0;

    scd_spi_command_decoder u_dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .i_reset_n_pin(i_reset_n_pin), .i_supply_fail(i_supply_fail),
        .i_direct_in(i_direct_in), .i_status_word(i_status_word),
        .o_so(o_so), .o_so_oe(o_so_oe), .o_output_drive(o_output_drive),
        .o_out_on(o_out_on), .o_duty(o_duty), .o_direct_dis(o_direct_dis),
        .o_slew(o_slew), .o_delay(o_delay), .o_fault_cfg(o_fault_cfg),
        .o_oc_cfg(o_oc_cfg), .o_global_cfg(o_global_cfg),
        .o_clock_cal(o_clock_cal), .o_pwm_enable(o_pwm_enable),
        .o_readout_select(o_readout_select),
        .o_watchdog_bit(o_watchdog_bit),
        .o_watchdog_strobe(o_watchdog_strobe));
    scd_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
        .i_so(o_so));

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz system clock
    always #25 i_clk = ~i_clk;

    // Count watchdog strobes so each frame can be tied to one pulse
    always @(posedge i_clk) begin
        if (o_watchdog_strobe === 1'b1) begin
            strobes++;
        end
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One whole word; select then stays high for eight clocks
    task automatic send(input logic [4:0] a, input logic [8:0] d);
        logic [47:0] seen;
        int n0;
        n0 = strobes;
        wd = ~wd;
        word = {wd, a, 1'b0, d};
        u_host.xfer({32'h0, word}, 16, seen);
        rb = seen[15:0];
        repeat (8) @(negedge i_clk);
        chk("wd_bit", {15'h0, wd}, {15'h0, o_watchdog_bit});
        chk("strobe", 16'h1, 16'(strobes - n0));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("cfg", 16'h0,
            16'({o_fault_cfg, o_oc_cfg, o_duty} != '0));
        chk("glob", 16'h0, {7'h0, o_global_cfg | o_clock_cal});
        chk("rst_misc", 16'h0, 16'({o_readout_select, o_output_drive,
            o_watchdog_bit, o_watchdog_strobe, o_out_on, o_slew,
            o_delay, o_direct_dis} != '0));
        chk("oe", 16'h0, {15'h0, o_so_oe});
    endtask

    // Every per-output register on both outputs, each slew code used
    task automatic t_map();
        for (int s = 0; s < 2; s++) begin
            send({1'b1, s[0], 3'h1}, {2'b01, 7'h2A + 7'(s)});
            chk("on", 16'h1, {15'h0, o_out_on[s]});
            chk("duty", 16'(7'h2A + 7'(s)), {9'h0, o_duty[s]});
            for (int k = 0; k < 3; k++) begin
                send({1'b1, s[0], 3'h2}, {3'h0, k[0], k[1:0], 3'(k + s)});
                chk("dirdis", 16'(k[0]), {15'h0, o_direct_dis[s]});
                chk("slew", 16'(k[1:0]), {14'h0, o_slew[s]});
                chk("delay", 16'(3'(k + s)), {13'h0, o_delay[s]});
            end
            send({1'b1, s[0], 3'h3}, 9'h1A5 ^ 9'(s));
            send({1'b1, s[0], 3'h4}, 9'h15A ^ 9'(s));
        end
        chk("fault0", 16'h1A5, {7'h0, o_fault_cfg[0]});
        chk("fault1", 16'h1A4, {7'h0, o_fault_cfg[1]});
        chk("oc0", 16'h15A, {7'h0, o_oc_cfg[0]});
        chk("oc1", 16'h15B, {7'h0, o_oc_cfg[1]});
        send(5'h05, 9'h07F);
        send(5'h07, 9'h16B);
        chk("glob", 16'h07F, {7'h0, o_global_cfg});
        chk("cal", 16'h16B, {7'h0, o_clock_cal});
    endtask

    // Readback codes, including a select with the top address bits set
    task automatic t_status();
        send(5'h00, 9'h011);
        chk("sel", 16'h11, {11'h0, o_readout_select});
        send(5'h18, 9'h005);
        chk("rb_pwm0", {1'b0, 5'h11, 1'b0, 9'h0AA}, rb);
        send(5'h08, 9'h000);
        chk("rb_glob", {1'b0, 5'h05, 1'b0, 9'h07F}, rb);
        send(5'h00, 9'h000);
        chk("rb_stat", i_status_word, rb);
        chk("glob_kept", 16'h07F, {7'h0, o_global_cfg});
        chk("duty_kept", 16'h2B, {9'h0, o_duty[1]});
    endtask

    // Short and long frames leave everything alone; an unmapped word writes no register
    task automatic t_bad();
        logic [47:0] seen;
        int n0;
        n0 = strobes;
        u_host.xfer(48'h1455, 15, seen);
        repeat (8) @(negedge i_clk);
        u_host.xfer(48'h11455, 17, seen);
        repeat (8) @(negedge i_clk);
        chk("no_strobe", 16'h0, 16'(strobes - n0));
        // Whole word to an unmapped address: latched, but writes nothing
        u_host.xfer(48'h1855, 16, seen);
        repeat (8) @(negedge i_clk);
        chk("glob_bad", 16'h07F, {7'h0, o_global_cfg});
        chk("unmapped_strobe", 16'h1, 16'(strobes - n0));
        chk("unmapped_wd", 16'h0, {15'h0, o_watchdog_bit});
    endtask

    // Two words in one select: last one lands, SO echoes the first
    task automatic t_multi();
        logic [47:0] seen;
        logic [15:0] w1;
        wd = ~wd;
        w1 = {~wd, 5'h05, 1'b0, 9'h0AA};
        u_host.xfer({16'h0, w1, wd, 5'h05, 1'b0, 9'h055}, 32, seen);
        repeat (8) @(negedge i_clk);
        chk("glob_multi", 16'h055, {7'h0, o_global_cfg});
        chk("echo", w1, seen[15:0]);
        chk("wd_multi", {15'h0, wd}, {15'h0, o_watchdog_bit});
    endtask

    // On bit, direct input and direct-disable against the drive state
    task automatic t_drive();
        send(5'h19, 9'h000);
        i_direct_in = 2'b01;
        send(5'h12, 9'h000);
        send(5'h11, 9'h000);
        chk("drv_dir", 16'h1, {14'h0, o_output_drive});
        send(5'h12, 9'h020);
        chk("drv_dis", 16'h0, {14'h0, o_output_drive});
        send(5'h11, 9'h080);
        chk("drv_on", 16'h1, {14'h0, o_output_drive});
        send(5'h05, 9'h080);
        send(5'h11, 9'h000);
        send(5'h12, 9'h000);
        chk("pwm_en", 16'h1, {15'h0, o_pwm_enable});
        chk("drv_pwm", 16'h0, {14'h0, o_output_drive});
    endtask

    // Reset pin and supply failure both wipe the registers
    task automatic t_clear();
        for (int k = 0; k < 2; k++) begin
            send(5'h05, 9'h0C3);
            i_reset_n_pin = k[0];
            i_supply_fail = k[0];
            repeat (6) @(negedge i_clk);
            i_reset_n_pin = 1'b1;
            i_supply_fail = 1'b0;
            repeat (6) @(negedge i_clk);
            chk("clr_glob", 16'h0, {7'h0, o_global_cfg});
            chk("clr_oc", 16'h0, 16'(o_oc_cfg != '0));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; inputs move on falling clock edges
    initial begin
        repeat (4) @(negedge i_clk);
        i_srst = 1'b0;
        repeat (6) @(negedge i_clk);
        t_reset();
        t_map();
        t_status();
        t_bad();
        t_multi();
        t_drive();
        t_clear();
        report_and_stop();
    end

    // Watchdog: thirty-two frames of under a microsecond each
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        report_and_stop();
    end
endmodule
